// >>> hdl/qbp_cfg.svh
// Register map, reset values and field masks of the quad port block.
// Assumes the processor issues one register access per cycle on clk.
// Function
// - Eight-pin first port, per-bit direction
// - One group bit pulls up first port
// - Six-pin second port, per-bit direction
// - One group bit pulls up second port
// - Third port direction; per-pin pull-up register
// - Two-pin fourth port, group pull-up bit
// - Reset loads all direction registers with ones
// - Direction zero drives latch, one floats
// - Group pull-up only on input bits
// - No pull-up on alternate output pins
// - Group pull-up clears; bits 0,1,3 used
// - Group bit one connects, zero disconnects
// - Level change on third port pins 4 to 6 raises interrupt request
// - Direction registers take bit and byte writes
// - Third, fourth ports share alternate functions
// - Output-mode read returns latch, unchanged
// - Input-mode read returns pin level
// - Input-mode write updates latch only
// - Third port pull-up register clears on reset
`ifndef QBP_CFG_SVH
`define QBP_CFG_SVH

// =====================================================
// Register addresses
`define QBP_ADDR_LAT_A   16'hFF00
`define QBP_ADDR_LAT_B   16'hFF01
`define QBP_ADDR_LAT_C   16'hFF02
`define QBP_ADDR_LAT_D   16'hFF03
`define QBP_ADDR_DIR_A   16'hFF20
`define QBP_ADDR_DIR_B   16'hFF21
`define QBP_ADDR_DIR_C   16'hFF22
`define QBP_ADDR_DIR_D   16'hFF23
`define QBP_ADDR_PU_C    16'hFF32
`define QBP_ADDR_PU_GRP  16'hFFF7

// =====================================================
// Reset values and masks
`define QBP_DIR_RST      8'hFF
`define QBP_ZERO         8'h00
`define QBP_DIR_B_FIXED  8'hC0
`define QBP_DIR_D_FIXED  8'hFC
`define QBP_LAT_B_MASK   8'h3F
`define QBP_LAT_D_MASK   8'h03
`define QBP_PU_GRP_MASK  8'h0B

// =====================================================
// Field positions
`define QBP_PU_BIT_A     0
`define QBP_PU_BIT_B     1
`define QBP_PU_BIT_D     3
`define QBP_IRQ_PIN_LO   4
`define QBP_CAPT_PIN     6
`define QBP_TMR_PIN      7

`endif

// >>> hdl/qbp_pkg.sv
// Types shared by the quad port block files.
// Assumes qbp_cfg.svh supplies the numeric constants.
package qbp_pkg;

    // =================================================
    // Data and register selection types
    typedef logic [7:0]  qbp_byte_t;
    typedef logic [15:0] qbp_addr_t;

    typedef enum logic [3:0] {
        QBP_SEL_NONE  = 4'b0000,
        QBP_SEL_LAT_A = 4'b0001,
        QBP_SEL_LAT_B = 4'b0010,
        QBP_SEL_LAT_C = 4'b0011,
        QBP_SEL_LAT_D = 4'b0100,
        QBP_SEL_DIR_A = 4'b0101,
        QBP_SEL_DIR_B = 4'b0110,
        QBP_SEL_DIR_C = 4'b0111,
        QBP_SEL_DIR_D = 4'b1000,
        QBP_SEL_PU_C  = 4'b1001,
        QBP_SEL_PU_G  = 4'b1010
    } qbp_sel_t;

endpackage : qbp_pkg

// >>> hdl/qbp_pin_cell.sv
// One port pin: output driver, enable and pull-up control.
// Assumes dir_in, latch and pu_req come from registers of the enclosing port.
`timescale 1ns/10ps
module qbp_pin_cell (
    input  wire logic dir_in,
    input  wire logic latch,
    input  wire logic alt_oe,
    input  wire logic alt_out,
    input  wire logic pu_req,
    input  wire logic pu_any_mode,
    output logic      pad_o,
    output logic      pad_oe,
    output logic      pull_en
);
    import qbp_pkg::*;

    // =================================================
    // Driver: a direction of zero turns the buffer on.
    assign pad_oe = ~dir_in;
    // Alternate output is merged with the latch by OR.
    assign pad_o  = latch | (alt_oe & alt_out);

    // =================================================
    // Pull-up: never on an alternate output pin.
    always_comb begin
        if (alt_oe) begin
            pull_en = 1'b0;
        end else if (pu_any_mode) begin
            pull_en = pu_req;
        end else begin
            pull_en = pu_req & dir_in;
        end
    end

endmodule : qbp_pin_cell

// >>> hdl/qbp_port_block.sv
// Four general-purpose ports with direction, latch and pull-up control.
// Assumes a single-cycle processor register port and synchronous pads.
`timescale 1ns/10ps
`include "qbp_cfg.svh"
module qbp_port_block (
    input  wire logic            clk,
    input  wire logic            rst_n,
    input  wire qbp_pkg::qbp_addr_t reg_addr,
    input  wire qbp_pkg::qbp_byte_t reg_wdata,
    input  wire logic            reg_wr,
    input  wire logic            reg_bit_op,
    input  wire logic [2:0]      reg_bit_sel,
    input  wire logic            reg_rd,
    output qbp_pkg::qbp_byte_t   reg_rdata,
    input  wire logic [7:0]      pin_a_i,
    output logic [7:0]           pin_a_o,
    output logic [7:0]           pin_a_oe,
    output logic [7:0]           pull_a,
    input  wire logic [5:0]      pin_b_i,
    output logic [5:0]           pin_b_o,
    output logic [5:0]           pin_b_oe,
    output logic [5:0]           pull_b,
    input  wire logic [7:0]      pin_c_i,
    output logic [7:0]           pin_c_o,
    output logic [7:0]           pin_c_oe,
    output logic [7:0]           pull_c,
    input  wire logic [1:0]      pin_d_i,
    output logic [1:0]           pin_d_o,
    output logic [1:0]           pin_d_oe,
    output logic [1:0]           pull_d,
    input  wire logic [7:0]      alt_c_oe,
    input  wire logic [7:0]      alt_c_out,
    input  wire logic            timer16_out,
    input  wire logic            timer16_oe,
    input  wire logic            buzzer_out,
    input  wire logic            buzzer_oe,
    output logic                 ext_irq_in_a,
    output logic                 ext_irq_in_b,
    output logic                 ext_irq_in_c,
    output logic [2:0]           ext_irq_edge,
    output logic                 capture_in,
    output logic                 timer8_in
);
    import qbp_pkg::*;

    // =================================================
    // Register storage
    qbp_byte_t dir_port_a;
    qbp_byte_t dir_port_b;
    qbp_byte_t dir_port_c;
    qbp_byte_t dir_port_d;
    qbp_byte_t lat_a;
    qbp_byte_t lat_b;
    qbp_byte_t lat_c;
    qbp_byte_t lat_d;
    qbp_byte_t group_pullup_enable;
    qbp_byte_t port_c_pullup_bits;
    qbp_sel_t  sel;
    logic [2:0] irq_prev;
    logic [1:0] irq_arm;

    // =================================================
    // Address decode, used by both write and read paths.
    function automatic qbp_sel_t decode(input qbp_addr_t a);
        unique case (a)
            `QBP_ADDR_LAT_A:  decode = QBP_SEL_LAT_A;
            `QBP_ADDR_LAT_B:  decode = QBP_SEL_LAT_B;
            `QBP_ADDR_LAT_C:  decode = QBP_SEL_LAT_C;
            `QBP_ADDR_LAT_D:  decode = QBP_SEL_LAT_D;
            `QBP_ADDR_DIR_A:  decode = QBP_SEL_DIR_A;
            `QBP_ADDR_DIR_B:  decode = QBP_SEL_DIR_B;
            `QBP_ADDR_DIR_C:  decode = QBP_SEL_DIR_C;
            `QBP_ADDR_DIR_D:  decode = QBP_SEL_DIR_D;
            `QBP_ADDR_PU_C:   decode = QBP_SEL_PU_C;
            `QBP_ADDR_PU_GRP: decode = QBP_SEL_PU_G;
            default:          decode = QBP_SEL_NONE;
        endcase
    endfunction : decode

    // Merge a byte write or a single-bit write into a register.
    function automatic qbp_byte_t merge(input qbp_byte_t old,
                                        input qbp_byte_t wd,
                                        input logic      bit_op,
                                        input logic [2:0] bsel);
        qbp_byte_t r;
        r = old;
        if (bit_op) begin
            r[bsel] = wd[0];
        end else begin
            r = wd;
        end
        merge = r;
    endfunction : merge

    // Port read: latch for output bits, pin for input bits.
    function automatic qbp_byte_t port_view(input qbp_byte_t dir_v,
                                            input qbp_byte_t lat_v,
                                            input qbp_byte_t pin_v);
        port_view = (~dir_v & lat_v) | (dir_v & pin_v);
    endfunction : port_view

    assign sel = decode(reg_addr);

    // =================================================
    // Direction registers; bit and byte writes, unused bits stay one.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_port_a <= `QBP_DIR_RST;
            dir_port_b <= `QBP_DIR_RST;
            dir_port_c <= `QBP_DIR_RST;
            dir_port_d <= `QBP_DIR_RST;
        end else if (reg_wr) begin
            unique case (sel)
                QBP_SEL_DIR_A: dir_port_a <= merge(dir_port_a, reg_wdata,
                                                   reg_bit_op, reg_bit_sel);
                QBP_SEL_DIR_B: dir_port_b <= merge(dir_port_b, reg_wdata,
                                                   reg_bit_op, reg_bit_sel)
                                             | `QBP_DIR_B_FIXED;
                QBP_SEL_DIR_C: dir_port_c <= merge(dir_port_c, reg_wdata,
                                                   reg_bit_op, reg_bit_sel);
                QBP_SEL_DIR_D: dir_port_d <= merge(dir_port_d, reg_wdata,
                                                   reg_bit_op, reg_bit_sel)
                                             | `QBP_DIR_D_FIXED;
                default: ;
            endcase
        end
    end

    // =================================================
    // Output latches; written in either mode, held until rewritten.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lat_a <= `QBP_ZERO;
            lat_b <= `QBP_ZERO;
            lat_c <= `QBP_ZERO;
            lat_d <= `QBP_ZERO;
        end else if (reg_wr) begin
            unique case (sel)
                QBP_SEL_LAT_A: lat_a <= merge(lat_a, reg_wdata,
                                              reg_bit_op, reg_bit_sel);
                QBP_SEL_LAT_B: lat_b <= merge(lat_b, reg_wdata, reg_bit_op, reg_bit_sel)
                                        & `QBP_LAT_B_MASK;
                QBP_SEL_LAT_C: lat_c <= merge(lat_c, reg_wdata, reg_bit_op, reg_bit_sel);
                QBP_SEL_LAT_D: lat_d <= merge(lat_d, reg_wdata, reg_bit_op, reg_bit_sel)
                                        & `QBP_LAT_D_MASK;
                default: ;
            endcase
        end
    end

    // =================================================
    // Pull-up option registers; both clear at reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            group_pullup_enable <= `QBP_ZERO;
            port_c_pullup_bits  <= `QBP_ZERO;
        end else if (reg_wr) begin
            unique case (sel)
                QBP_SEL_PU_G: begin
                    group_pullup_enable <= merge(group_pullup_enable,
                                                 reg_wdata, reg_bit_op,
                                                 reg_bit_sel)
                                           & `QBP_PU_GRP_MASK;
                end
                QBP_SEL_PU_C: begin
                    port_c_pullup_bits <= merge(port_c_pullup_bits,
                                                reg_wdata, reg_bit_op,
                                                reg_bit_sel);
                end
                default: ;
            endcase
        end
    end

    // =================================================
    // Registered read data; reads never disturb the latches.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= `QBP_ZERO;
        end else if (reg_rd) begin
            unique case (sel)
                QBP_SEL_LAT_A: reg_rdata <= port_view(dir_port_a, lat_a,
                                                      pin_a_i);
                QBP_SEL_LAT_B: reg_rdata <= port_view(dir_port_b, lat_b,
                                                      {2'b00, pin_b_i})
                                            & `QBP_LAT_B_MASK;
                QBP_SEL_LAT_C: reg_rdata <= port_view(dir_port_c, lat_c,
                                                      pin_c_i);
                QBP_SEL_LAT_D: reg_rdata <= port_view(dir_port_d, lat_d,
                                                      {6'b000000, pin_d_i})
                                            & `QBP_LAT_D_MASK;
                QBP_SEL_DIR_A: reg_rdata <= dir_port_a;
                QBP_SEL_DIR_B: reg_rdata <= dir_port_b;
                QBP_SEL_DIR_C: reg_rdata <= dir_port_c;
                QBP_SEL_DIR_D: reg_rdata <= dir_port_d;
                QBP_SEL_PU_C:  reg_rdata <= port_c_pullup_bits;
                QBP_SEL_PU_G:  reg_rdata <= group_pullup_enable;
                default:       reg_rdata <= `QBP_ZERO;
            endcase
        end
    end

    // =================================================
    // Pin cells for all four ports.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_port_a
            qbp_pin_cell u_cell (
                .dir_in      (dir_port_a[gi]),
                .latch       (lat_a[gi]),
                .alt_oe      (1'b0),
                .alt_out     (1'b0),
                .pu_req      (group_pullup_enable[`QBP_PU_BIT_A]),
                .pu_any_mode (1'b0),
                .pad_o       (pin_a_o[gi]),
                .pad_oe      (pin_a_oe[gi]),
                .pull_en     (pull_a[gi])
            );
        end
        for (gi = 0; gi < 6; gi = gi + 1) begin : g_port_b
            qbp_pin_cell u_cell (
                .dir_in      (dir_port_b[gi]),
                .latch       (lat_b[gi]),
                .alt_oe      (1'b0),
                .alt_out     (1'b0),
                .pu_req      (group_pullup_enable[`QBP_PU_BIT_B]),
                .pu_any_mode (1'b0),
                .pad_o       (pin_b_o[gi]),
                .pad_oe      (pin_b_oe[gi]),
                .pull_en     (pull_b[gi])
            );
        end
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_port_c
            qbp_pin_cell u_cell (
                .dir_in      (dir_port_c[gi]),
                .latch       (lat_c[gi]),
                .alt_oe      (alt_c_oe[gi]),
                .alt_out     (alt_c_out[gi]),
                .pu_req      (port_c_pullup_bits[gi]),
                .pu_any_mode (1'b1),
                .pad_o       (pin_c_o[gi]),
                .pad_oe      (pin_c_oe[gi]),
                .pull_en     (pull_c[gi])
            );
        end
    endgenerate

    // Fourth port: timer output on pin 0, buzzer output on pin 1.
    qbp_pin_cell u_cell_d0 (
        .dir_in      (dir_port_d[0]),
        .latch       (lat_d[0]),
        .alt_oe      (timer16_oe),
        .alt_out     (timer16_out),
        .pu_req      (group_pullup_enable[`QBP_PU_BIT_D]),
        .pu_any_mode (1'b0),
        .pad_o       (pin_d_o[0]),
        .pad_oe      (pin_d_oe[0]),
        .pull_en     (pull_d[0])
    );
    qbp_pin_cell u_cell_d1 (
        .dir_in      (dir_port_d[1]),
        .latch       (lat_d[1]),
        .alt_oe      (buzzer_oe),
        .alt_out     (buzzer_out),
        .pu_req      (group_pullup_enable[`QBP_PU_BIT_D]),
        .pu_any_mode (1'b0),
        .pad_o       (pin_d_o[1]),
        .pad_oe      (pin_d_oe[1]),
        .pull_en     (pull_d[1])
    );

    // =================================================
    // Alternate inputs; the pad level reaches them in any mode.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_irq_in_a <= 1'b0;
            ext_irq_in_b <= 1'b0;
            ext_irq_in_c <= 1'b0;
            capture_in   <= 1'b0;
            timer8_in    <= 1'b0;
        end else begin
            ext_irq_in_a <= pin_c_i[`QBP_IRQ_PIN_LO];
            ext_irq_in_b <= pin_c_i[`QBP_IRQ_PIN_LO + 1];
            ext_irq_in_c <= pin_c_i[`QBP_CAPT_PIN];
            capture_in   <= pin_c_i[`QBP_CAPT_PIN];
            timer8_in    <= pin_c_i[`QBP_TMR_PIN];
        end
    end

    // Any level change raises a pulse; irq_arm hides the false edge after reset.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_prev     <= 3'b000;
            irq_arm      <= 2'b00;
            ext_irq_edge <= 3'b000;
        end else begin
            irq_prev     <= {ext_irq_in_c, ext_irq_in_b, ext_irq_in_a};
            irq_arm      <= {irq_arm[0], 1'b1};
            ext_irq_edge <= (irq_prev ^ {ext_irq_in_c, ext_irq_in_b, ext_irq_in_a})
                            & {3{irq_arm[1]}};
        end
    end

    // =================================================
    // Checks
    logic dir_a_written;

    // Records whether the first direction register was ever written.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dir_a_written <= 1'b0;
        end else if (reg_wr && sel == QBP_SEL_DIR_A) begin
            dir_a_written <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    chk_dir_reset_ones: assert property (
        !dir_a_written |-> (dir_port_a == `QBP_DIR_RST && pin_a_oe == 8'h00))
        else $error("Direction register left its reset value unwritten.");
    chk_dir_fixed_ones: assert property (
        dir_port_b[7:6] == 2'b11 && dir_port_d[7:2] == 6'h3F)
        else $error("Unused direction bits did not read as one.");
    chk_dir_byte_write: assert property (
        reg_wr && !reg_bit_op && sel == QBP_SEL_DIR_A
        |=> dir_port_a == $past(reg_wdata))
        else $error("Byte write to direction register was lost.");
    chk_dir_bit_write: assert property (
        reg_wr && reg_bit_op && sel == QBP_SEL_DIR_C
        |=> dir_port_c[$past(reg_bit_sel)] == $past(reg_wdata[0])
            && $countones(dir_port_c ^ $past(dir_port_c)) <= 1)
        else $error("Bit write to direction register touched other bits.");
    chk_oe_follows_dir: assert property (
        pin_a_oe == ~dir_port_a && pin_d_oe == ~dir_port_d[1:0])
        else $error("Output enable does not follow direction.");
    chk_pull_out_off: assert property (
        (pin_a_oe & pull_a) == 8'h00 && (pin_b_oe & pull_b) == 6'h00)
        else $error("Pull-up applied to an output bit.");
    chk_pull_alt_off: assert property (
        (alt_c_oe & pull_c) == 8'h00 && !(buzzer_oe && pull_d[1]))
        else $error("Pull-up applied to an alternate output pin.");
    chk_port_c_pull: assert property (
        pull_c == (port_c_pullup_bits & ~alt_c_oe))
        else $error("Third port pull-up does not follow its register.");
    chk_read_port: assert property (
        reg_rd && sel == QBP_SEL_LAT_A
        |=> reg_rdata == ((~$past(dir_port_a) & $past(lat_a))
                         | ($past(dir_port_a) & $past(pin_a_i)))
            && lat_a == $past(lat_a))
        else $error("Port read returned wrong data or moved the latch.");
    chk_input_write: assert property (
        reg_wr && !reg_bit_op && sel == QBP_SEL_LAT_A && dir_port_a == 8'hFF
        |=> pin_a_oe == 8'h00 && lat_a == $past(reg_wdata))
        else $error("Input-mode write drove the pin or missed the latch.");
    chk_irq_on_change: assert property (
        $changed(pin_c_i[4]) && irq_arm[1] |-> ##2 ext_irq_edge[0])
        else $error("Level change on interrupt pin raised no request.");
    chk_grp_reserved: assert property (
        (group_pullup_enable & ~`QBP_PU_GRP_MASK) == 8'h00)
        else $error("Unused group pull-up bits became set.");

endmodule : qbp_port_block

// >>> dv/qbp_pad_model.sv
// Pad model for one port: resolves each pad from driver, outside source and pull-up.
// Assumes one instance per port, clocked by the block's system clock.
`timescale 1ns/10ps
module qbp_pad_model #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] o,
    input  wire logic [W-1:0] oe,
    input  wire logic [W-1:0] pull,
    input  wire logic [W-1:0] ext_en,
    input  wire logic [W-1:0] ext_val,
    input  wire logic         clk,
    output logic [W-1:0]      pin
);
    logic flt = 1'h0;
    // =========================================================
    // Floating pads show a level that changes every cycle.
    always @(posedge clk) flt <= ~flt;
    // The block's driver wins; outside sources only act on pads left as inputs.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            pin[i] = oe[i] ? o[i] : ext_en[i] ? ext_val[i] : pull[i] ? 1'h1 : flt;
        end
    end
endmodule : qbp_pad_model

// >>> dv/tb_top.sv
// Self-checking bench of the quad port block with pad models on every port.
// Assumes qbp_cfg.svh is on the include path and the design files compile first.
`timescale 1ns/10ps
`include "qbp_cfg.svh"
module tb_top;
    import qbp_pkg::*;
    logic       clk = 1'h0, rst_n = 1'h0, reg_wr = 1'h0, reg_bit_op = 1'h0, reg_rd = 1'h0;
    logic [2:0] reg_bit_sel = 3'h0, ext_irq_edge;
    qbp_addr_t  reg_addr = 16'h0000;
    qbp_byte_t  reg_wdata = 8'h00, reg_rdata;
    logic [7:0] pin_a_i, pin_a_o, pin_a_oe, pull_a, pin_c_i, pin_c_o, pin_c_oe, pull_c;
    logic [5:0] pin_b_i, pin_b_o, pin_b_oe, pull_b;
    logic [1:0] pin_d_i, pin_d_o, pin_d_oe, pull_d;
    logic [7:0] alt_c_oe = 8'h00, alt_c_out = 8'h00;
    logic       timer16_out = 1'h0, timer16_oe = 1'h0, buzzer_out = 1'h0, buzzer_oe = 1'h0;
    logic       ext_irq_in_a, ext_irq_in_b, ext_irq_in_c, capture_in, timer8_in;
    logic [7:0] ext_val_a = 8'h5A, ext_val_c = 8'h00;
    logic [5:0] ext_en_b = 6'h00, ext_val_b = 6'h00;
    qbp_byte_t  dmask [4] = '{8'h00, 8'hC0, 8'h00, 8'hFC};
    int         errors = 0, check_count = 0, n;

    // =========================================================
    // Design and pad models.
    qbp_port_block dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_bit_op,
        .reg_bit_sel, .reg_rd, .reg_rdata, .pin_a_i, .pin_a_o, .pin_a_oe, .pull_a,
        .pin_b_i, .pin_b_o, .pin_b_oe, .pull_b, .pin_c_i, .pin_c_o, .pin_c_oe, .pull_c,
        .pin_d_i, .pin_d_o, .pin_d_oe, .pull_d, .alt_c_oe, .alt_c_out, .timer16_out,
        .timer16_oe, .buzzer_out, .buzzer_oe, .ext_irq_in_a, .ext_irq_in_b, .ext_irq_in_c,
        .ext_irq_edge, .capture_in, .timer8_in);
    qbp_pad_model #(.W(8)) pad_a (.o(pin_a_o), .oe(pin_a_oe), .pull(pull_a),
        .ext_en(8'hFF), .ext_val(ext_val_a), .clk, .pin(pin_a_i));
    qbp_pad_model #(.W(6)) pad_b (.o(pin_b_o), .oe(pin_b_oe), .pull(pull_b),
        .ext_en(ext_en_b), .ext_val(ext_val_b), .clk, .pin(pin_b_i));
    qbp_pad_model #(.W(8)) pad_c (.o(pin_c_o), .oe(pin_c_oe), .pull(pull_c),
        .ext_en(8'hFF), .ext_val(ext_val_c), .clk, .pin(pin_c_i));
    qbp_pad_model #(.W(2)) pad_d (.o(pin_d_o), .oe(pin_d_oe), .pull(pull_d),
        .ext_en(2'h0), .ext_val(2'h0), .clk, .pin(pin_d_i));

    // =========================================================
    // Clock, access tasks and the closing task.
    always #5 clk = ~clk;
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic wr(input qbp_addr_t a, input qbp_byte_t d, input logic b = 1'h0,
                      input logic [2:0] k = 3'h0);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_bit_op <= b;
        reg_bit_sel <= k;
        reg_wr <= 1'h1;
        @(posedge clk);
        reg_wr <= 1'h0;
        #1;
    endtask : wr
    task automatic rd(input qbp_addr_t a, input qbp_byte_t e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge clk);
        reg_rd <= 1'h0;
        #1;
        chk("reg_rdata", reg_rdata, e);
    endtask : rd
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : results
    // Cuts a hang short; the tests need well under two thousand cycles.
    initial begin
        #50000;
        errors++;
        results();
    end

    // =========================================================
    // Test sequence.
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        for (int i = 0; i < 4; i++) rd(`QBP_ADDR_DIR_A + 16'(i), 8'hFF);
        rd(`QBP_ADDR_PU_GRP, 8'h00);
        rd(`QBP_ADDR_PU_C, 8'h00);
        rd(16'hFF10, 8'h00);
        wr(`QBP_ADDR_LAT_A, 8'h3C);
        chk("pin_a_oe", pin_a_oe, 8'h00);
        chk("pin_a_o", pin_a_o, 8'h3C);
        rd(`QBP_ADDR_LAT_A, 8'h5A);
        $display("test reset done");
        for (int i = 0; i < 4; i++) wr(`QBP_ADDR_DIR_A + 16'(i), 8'h00);
        for (int i = 0; i < 4; i++) rd(`QBP_ADDR_DIR_A + 16'(i), dmask[i]);
        chk("pin_a_oe", pin_a_oe, 8'hFF);
        chk("pin_b_oe", {2'h0, pin_b_oe}, 8'h3F);
        wr(`QBP_ADDR_LAT_A, 8'hA5);
        chk("pin_a_o", pin_a_o, 8'hA5);
        wr(`QBP_ADDR_LAT_B, 8'hFF);
        chk("pin_b_o", {2'h0, pin_b_o}, 8'h3F);
        rd(`QBP_ADDR_LAT_A, 8'hA5);
        wr(`QBP_ADDR_DIR_A, 8'h01, 1'h1, 3'h3);
        rd(`QBP_ADDR_DIR_A, 8'h08);
        rd(`QBP_ADDR_LAT_A, 8'hAD);
        @(posedge clk);
        ext_val_a <= 8'h00;
        rd(`QBP_ADDR_LAT_A, 8'hA5);
        chk("pin_a_o", pin_a_o, 8'hA5);
        $display("test direction done");
        for (int i = 0; i < 4; i++) wr(`QBP_ADDR_DIR_A + 16'(i), 8'hFF);
        wr(`QBP_ADDR_PU_GRP, 8'h0B);
        rd(`QBP_ADDR_PU_GRP, 8'h0B);
        chk("pull_a", pull_a, 8'hFF);
        chk("pull_b", {2'h0, pull_b}, 8'h3F);
        chk("pull_d", {6'h0, pull_d}, 8'h03);
        wr(`QBP_ADDR_DIR_A, 8'h0F);
        chk("pull_a", pull_a, 8'h0F);
        wr(`QBP_ADDR_PU_GRP, 8'h08);
        chk("pull_a", pull_a, 8'h00);
        @(posedge clk);
        ext_en_b <= 6'h3F;
        ext_val_b <= 6'h15;
        rd(`QBP_ADDR_LAT_B, 8'h15);
        $display("test pull-up done");
        wr(`QBP_ADDR_PU_C, 8'h5A);
        chk("pull_c", pull_c, 8'h5A);
        wr(`QBP_ADDR_DIR_C, 8'hED);
        wr(`QBP_ADDR_DIR_C, 8'h00, 1'h1, 3'h1);
        wr(`QBP_ADDR_DIR_D, 8'h00);
        @(posedge clk);
        alt_c_oe <= 8'h02;
        alt_c_out <= 8'h02;
        timer16_oe <= 1'h1;
        timer16_out <= 1'h1;
        buzzer_oe <= 1'h1;
        buzzer_out <= 1'h1;
        #1;
        chk("pull_c", pull_c, 8'h58);
        chk("pin_c_o", pin_c_o, 8'h02);
        chk("pin_d_o", {6'h0, pin_d_o}, 8'h03);
        chk("pull_d", {6'h0, pull_d}, 8'h00);
        $display("test alternate done");
        wr(`QBP_ADDR_LAT_C, 8'h10);
        n = 0;
        repeat (4) begin
            @(posedge clk);
            #1;
            n += int'(ext_irq_edge[0] === 1'h1);
        end
        chk("ext_irq_in_a", {7'h0, ext_irq_in_a}, 8'h01);
        chk("irq pulses", 8'(n), 8'h01);
        @(posedge clk);
        ext_val_c <= 8'hC0;
        repeat (2) @(posedge clk);
        #1;
        chk("alt_in", {4'h0, ext_irq_in_b, ext_irq_in_c, capture_in, timer8_in}, 8'h07);
        $display("test interrupt done");
        results();
    end
endmodule : tb_top
